// ==== temp_limit_defines.svh ====
// constants of the temperature limit register access block
`ifndef TEMP_LIMIT_DEFINES_SVH
`define TEMP_LIMIT_DEFINES_SVH

// bus address: fixed prefix, then the three select pins, then direction
`define DEV_ADDR_PREFIX   4'h9
`define RW_READ           1'b1

// pointer values of the limit registers
`define PTR_LOW_LIMIT     8'h02
`define PTR_HIGH_LIMIT    8'h03
`define PTR_NV_LOW_LIMIT  8'h12
`define PTR_NV_HIGH_LIMIT 8'h13
`define PTR_RESET         8'h00

// delivered contents of the nonvolatile copies
`define NV_LOW_DEFAULT    16'h4b00
`define NV_HIGH_DEFAULT   16'h5000

// field layout
`define LIMIT_SIGN_BIT    15
`define RES_BASE_MASK     16'h007f
`define BYTE_BITS         4'h8
`define BIT_CNT_RESET     4'h0

// data byte index inside a write
`define DIDX_UPPER        2'h0
`define DIDX_LOWER        2'h1
`define DIDX_EXTRA        2'h2

// timing
`define CLK_PERIOD_NS     25
`define NV_PROG_TIME_NS   5000000

`endif

// ==== temp_limit_pkg.sv ====
// types shared by the temperature limit register access block
package temp_limit_pkg;

  typedef logic [15:0] limit_t;
  typedef logic [7:0]  byte_t;
  typedef logic [1:0]  resolution_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK
  } slave_state_e;

endpackage : temp_limit_pkg

// ==== temp_limit_if.sv ====
// carriers between the limit access top and its two helper modules

////////////////////////////////////////////////////////////////////////////////
interface bus_event_if;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic sda_bit;
  modport detector (output scl_rise, scl_fall, start_cond, stop_cond, sda_bit);
  modport user     (input  scl_rise, scl_fall, start_cond, stop_cond, sda_bit);
endinterface : bus_event_if

////////////////////////////////////////////////////////////////////////////////
interface nv_prog_if;
  logic                 start;
  logic                 sel_high;
  temp_limit_pkg::limit_t wdata;
  logic                 busy;
  temp_limit_pkg::limit_t low_copy;
  temp_limit_pkg::limit_t high_copy;
  modport store (input start, sel_high, wdata, output busy, low_copy, high_copy);
  modport user  (output start, sel_high, wdata, input busy, low_copy, high_copy);
endinterface : nv_prog_if

// ==== bus_event_detect.sv ====
// start, stop and clock edge detection on the two-wire bus
module bus_event_detect (
  // clock and reset
  input  wire logic I_CLK,
  input  wire logic I_RST,
  // bus pins
  input  wire logic I_SCL,
  input  wire logic I_SDA,
  // events
  bus_event_if.detector ev
);

  logic prev_scl;
  logic prev_sda;
  logic next_prev_scl;
  logic next_prev_sda;

  always_comb begin
    next_prev_scl = I_SCL;
    next_prev_sda = I_SDA;
  end

  // idle bus is high on both wires
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      prev_scl <= 1'b1;
      prev_sda <= 1'b1;
    end else begin
      prev_scl <= next_prev_scl;
      prev_sda <= next_prev_sda;
    end
  end

  assign ev.scl_rise   = I_SCL & ~prev_scl;
  assign ev.scl_fall   = ~I_SCL & prev_scl;
  // data moving while clock stays high marks a frame boundary
  assign ev.start_cond = I_SCL & prev_scl & prev_sda & ~I_SDA;
  assign ev.stop_cond  = I_SCL & prev_scl & ~prev_sda & I_SDA;
  assign ev.sda_bit    = I_SDA;

endmodule : bus_event_detect

// ==== nv_limit_store.sv ====
// nonvolatile limit copies with self-timed program cycle
`include "temp_limit_defines.svh"
module nv_limit_store #(
  parameter int unsigned PROG_CYCLES = 1
) (
  // clock and reset
  input  wire logic I_CLK,
  input  wire logic I_RST,
  // program port
  nv_prog_if.store  nv
);
  import temp_limit_pkg::*;

  // storage is never reset: it stands for cells that keep their content
  limit_t      low_copy  = `NV_LOW_DEFAULT;
  limit_t      high_copy = `NV_HIGH_DEFAULT;
  logic [31:0] prog_cnt;
  logic [31:0] next_prog_cnt;
  logic        sel_high;
  logic        next_sel_high;
  limit_t      pend_data;
  limit_t      next_pend_data;
  logic        commit;

  always_comb begin
    next_prog_cnt  = prog_cnt;
    next_sel_high  = sel_high;
    next_pend_data = pend_data;
    commit         = 1'b0;
    if (prog_cnt != 32'h0) begin
      next_prog_cnt = prog_cnt - 32'h1;
      commit        = (prog_cnt == 32'h1);
    end else if (nv.start) begin
      next_prog_cnt  = PROG_CYCLES;
      next_sel_high  = nv.sel_high;
      next_pend_data = nv.wdata;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      prog_cnt  <= 32'h0;
      sel_high  <= 1'b0;
      pend_data <= '0;
    end else begin
      prog_cnt  <= next_prog_cnt;
      sel_high  <= next_sel_high;
      pend_data <= next_pend_data;
    end
  end

  // content changes only at the end of the program time
  always_ff @(posedge I_CLK) begin
    if (commit && !sel_high) low_copy <= pend_data;
    if (commit && sel_high) high_copy <= pend_data;
  end

  assign nv.busy      = (prog_cnt != 32'h0);
  assign nv.low_copy  = low_copy;
  assign nv.high_copy = high_copy;

endmodule : nv_limit_store

// ==== temp_limit_access.sv ====
// two-wire slave access to the volatile and nonvolatile temperature limits
`include "temp_limit_defines.svh"
//
// Overview of operation
// - busy, lock or lockdown discards volatile limit write
// - locked writes still acknowledge every byte
// - busy: ack address and pointer, nack data
// - write leaves pointer on the written register
// - read address 1001AAA1 matched against select pins
// - upper byte first, master ack requests lower
// - master nack ends read, data line released
// - master ack after lower byte repeats register
// - reset copies nonvolatile limits into volatile
// - alarm compares volatile limits only
// - limits are 16-bit two's complement, sign 15
// - writes keep resolution bits, zero the rest
// - reads show resolution bits, zero the rest
// - nonvolatile write: address, pointer 12h/13h, two bytes
// - data bytes beyond the second are ignored
// - short write before stop or start dropped
// - nonvolatile copies survive power-down and reset
// - stop starts timed program, busy until done
// - nonvolatile writes gated like volatile ones
// - lockdown overrides lock, never clearable
// - delivered copies hold 4B00h and 5000h
module temp_limit_access
  import temp_limit_pkg::*;
#(
  parameter int unsigned P_NV_PROG_TIME_NS = `NV_PROG_TIME_NS
) (
  // clock and reset
  input  wire logic                        I_CLK,
  input  wire logic                        I_RST,
  // two-wire bus, data line open drain
  input  wire logic                        I_SCL,
  input  wire logic                        I_SDA,
  output      logic                        O_SDA_OUT,
  output      logic                        O_SDA_OE,
  // device address select pins
  input  wire logic [2:0]                  I_ADDRESS_SELECT_PINS,
  // configuration bits held elsewhere in the device
  input  wire logic                        I_RESOLUTION_SELECT_HIGH,
  input  wire logic                        I_RESOLUTION_SELECT_LOW,
  input  wire logic                        I_REGISTER_LOCK_BIT,
  input  wire logic                        I_PERMANENT_LOCKDOWN_BIT,
  // status and limits toward the alarm comparator
  output      logic                        O_NV_BUSY_FLAG,
  output      temp_limit_pkg::limit_t      O_LOW_LIMIT,
  output      temp_limit_pkg::limit_t      O_HIGH_LIMIT
);
  import temp_limit_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // program cycle length, rounded up so the copy is never cut short
  localparam int unsigned PROG_CYCLES =
    (P_NV_PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  //////////////////////////////////////////////////////////////////////////////
  bus_event_if ev ();
  nv_prog_if   nv ();

  bus_event_detect u_detect (
    .I_CLK (I_CLK),
    .I_RST (I_RST),
    .I_SCL (I_SCL),
    .I_SDA (I_SDA),
    .ev    (ev)
  );

  nv_limit_store #(
    .PROG_CYCLES (PROG_CYCLES)
  ) u_nv_store (
    .I_CLK (I_CLK),
    .I_RST (I_RST),
    .nv    (nv)
  );

  //////////////////////////////////////////////////////////////////////////////
  // state
  slave_state_e state;
  slave_state_e next_state;
  logic [3:0]   bit_cnt;
  logic [3:0]   next_bit_cnt;
  byte_t        shreg;
  byte_t        next_shreg;
  logic         rw_read;
  logic         next_rw_read;
  byte_t        pointer;
  byte_t        next_pointer;
  logic [1:0]   data_idx;
  logic [1:0]   next_data_idx;
  byte_t        upper_hold;
  byte_t        next_upper_hold;
  limit_t       low_limit;
  limit_t       next_low_limit;
  limit_t       high_limit;
  limit_t       next_high_limit;
  logic         nv_pending;
  logic         next_nv_pending;
  limit_t       nv_data;
  limit_t       next_nv_data;
  logic         sda_oe;
  logic         next_sda_oe;
  logic         rd_low;
  logic         next_rd_low;
  logic         nv_start;

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  resolution_t res_sel;
  limit_t      res_mask;
  limit_t      rd_word;
  limit_t      wr_word;
  logic        locked;
  logic        busy;
  logic        addr_match;
  logic        ptr_volatile;
  logic        ptr_nv;

  assign res_sel  = {I_RESOLUTION_SELECT_HIGH, I_RESOLUTION_SELECT_LOW};
  // 9 bits keep 15..7, each step keeps one more low bit
  assign res_mask = ~(`RES_BASE_MASK >> res_sel);
  // lockdown wins regardless of the reversible lock
  assign locked   = I_PERMANENT_LOCKDOWN_BIT | I_REGISTER_LOCK_BIT;
  assign busy     = nv.busy;
  assign addr_match = (shreg[7:1] == {`DEV_ADDR_PREFIX, I_ADDRESS_SELECT_PINS});
  assign ptr_volatile = (pointer == `PTR_LOW_LIMIT) || (pointer == `PTR_HIGH_LIMIT);
  assign ptr_nv       = (pointer == `PTR_NV_LOW_LIMIT) || (pointer == `PTR_NV_HIGH_LIMIT);
  // sign sits in the top bit and is never masked off
  assign wr_word  = {upper_hold, shreg} & res_mask;

  // read source, trimmed to the current resolution
  always_comb begin
    case (pointer)
      `PTR_LOW_LIMIT:     rd_word = low_limit & res_mask;
      `PTR_HIGH_LIMIT:    rd_word = high_limit & res_mask;
      `PTR_NV_LOW_LIMIT:  rd_word = nv.low_copy & res_mask;
      `PTR_NV_HIGH_LIMIT: rd_word = nv.high_copy & res_mask;
      default:            rd_word = '0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // bus protocol and register update
  always_comb begin
    next_state      = state;
    next_bit_cnt    = bit_cnt;
    next_shreg      = shreg;
    next_rw_read    = rw_read;
    next_pointer    = pointer;
    next_data_idx   = data_idx;
    next_upper_hold = upper_hold;
    next_low_limit  = low_limit;
    next_high_limit = high_limit;
    next_nv_pending = nv_pending;
    next_nv_data    = nv_data;
    next_sda_oe     = sda_oe;
    next_rd_low     = rd_low;
    nv_start        = 1'b0;
    if (ev.start_cond) begin
      // repeated start drops any unfinished or unprogrammed write
      next_state      = ST_ADDR;
      next_bit_cnt    = `BIT_CNT_RESET;
      next_sda_oe     = 1'b0;
      next_nv_pending = 1'b0;
    end else if (ev.stop_cond) begin
      next_state      = ST_IDLE;
      next_sda_oe     = 1'b0;
      next_nv_pending = 1'b0;
      // only a complete, ungated write reaches the program engine
      if (nv_pending && !locked && !busy) begin
        nv_start = 1'b1;
      end
    end else begin
      case (state)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (ev.scl_rise) begin
            next_shreg   = {shreg[6:0], ev.sda_bit};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (ev.scl_fall && bit_cnt == `BYTE_BITS) begin
            next_bit_cnt = `BIT_CNT_RESET;
            case (state)
              ST_ADDR: begin
                if (addr_match) begin
                  next_sda_oe  = 1'b1;
                  next_rw_read = (shreg[0] == `RW_READ);
                  next_state   = ST_ADDR_ACK;
                end else begin
                  next_state = ST_IDLE;
                end
              end
              ST_PTR: begin
                // pointer byte is acked even while busy
                next_pointer  = shreg;
                next_data_idx = `DIDX_UPPER;
                next_sda_oe   = 1'b1;
                next_state    = ST_PTR_ACK;
              end
              default: begin
                // busy refuses data bytes; locks still ack them
                next_sda_oe = !busy;
                next_state  = ST_WDATA_ACK;
                case (data_idx)
                  `DIDX_UPPER: begin
                    next_upper_hold = shreg;
                    next_data_idx   = `DIDX_LOWER;
                  end
                  `DIDX_LOWER: begin
                    next_data_idx = `DIDX_EXTRA;
                    if (ptr_volatile && !busy && !locked) begin
                      if (pointer == `PTR_LOW_LIMIT) begin
                        next_low_limit = wr_word;
                      end else begin
                        next_high_limit = wr_word;
                      end
                    end
                    if (ptr_nv) begin
                      next_nv_pending = 1'b1;
                      next_nv_data    = wr_word;
                    end
                  end
                  default: begin
                    next_data_idx = `DIDX_EXTRA;
                  end
                endcase
              end
            endcase
          end
        end
        ST_ADDR_ACK: begin
          if (ev.scl_fall) begin
            next_bit_cnt = `BIT_CNT_RESET;
            if (rw_read) begin
              // pointer left by the last write selects the register
              next_shreg  = rd_word[15:8];
              next_rd_low = 1'b1;
              next_sda_oe = ~rd_word[`LIMIT_SIGN_BIT];
              next_state  = ST_RDATA;
            end else begin
              next_sda_oe = 1'b0;
              next_state  = ST_PTR;
            end
          end
        end
        ST_PTR_ACK, ST_WDATA_ACK: begin
          if (ev.scl_fall) begin
            next_sda_oe  = 1'b0;
            next_bit_cnt = `BIT_CNT_RESET;
            next_state   = ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (ev.scl_rise) begin
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (ev.scl_fall) begin
            if (bit_cnt == `BYTE_BITS) begin
              next_sda_oe = 1'b0;
              next_state  = ST_RDATA_ACK;
            end else begin
              next_shreg  = {shreg[6:0], 1'b0};
              next_sda_oe = ~shreg[6];
            end
          end
        end
        ST_RDATA_ACK: begin
          if (ev.scl_rise && ev.sda_bit) begin
            // nack: keep the line released until stop or start
            next_state = ST_IDLE;
          end else if (ev.scl_fall) begin
            // ack: next byte, wrapping from lower back to upper
            next_bit_cnt = `BIT_CNT_RESET;
            next_shreg   = rd_low ? rd_word[7:0] : rd_word[15:8];
            next_sda_oe  = rd_low ? ~rd_word[7] : ~rd_word[`LIMIT_SIGN_BIT];
            next_rd_low  = !rd_low;
            next_state   = ST_RDATA;
          end
        end
        default: begin
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      state      <= ST_IDLE;
      bit_cnt    <= `BIT_CNT_RESET;
      shreg      <= '0;
      rw_read    <= 1'b0;
      pointer    <= `PTR_RESET;
      data_idx   <= `DIDX_UPPER;
      upper_hold <= '0;
      // volatile limits come up from the stored copies
      low_limit  <= nv.low_copy;
      high_limit <= nv.high_copy;
      nv_pending <= 1'b0;
      nv_data    <= '0;
      sda_oe     <= 1'b0;
      rd_low     <= 1'b0;
    end else begin
      state      <= next_state;
      bit_cnt    <= next_bit_cnt;
      shreg      <= next_shreg;
      rw_read    <= next_rw_read;
      pointer    <= next_pointer;
      data_idx   <= next_data_idx;
      upper_hold <= next_upper_hold;
      low_limit  <= next_low_limit;
      high_limit <= next_high_limit;
      nv_pending <= next_nv_pending;
      nv_data    <= next_nv_data;
      sda_oe     <= next_sda_oe;
      rd_low     <= next_rd_low;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // program request toward the nonvolatile store
  assign nv.start    = nv_start;
  assign nv.sel_high = (pointer == `PTR_NV_HIGH_LIMIT);
  assign nv.wdata    = nv_data;

  //////////////////////////////////////////////////////////////////////////////
  // outputs; the alarm side sees the volatile pair only
  assign O_SDA_OUT      = 1'b0;
  assign O_SDA_OE       = sda_oe;
  assign O_NV_BUSY_FLAG = busy;
  assign O_LOW_LIMIT    = low_limit;
  assign O_HIGH_LIMIT   = high_limit;

endmodule : temp_limit_access

// ==== temp_limit_sva.sv ====
// port checker of the temperature limit access block
`include "temp_limit_defines.svh"
module temp_limit_sva
  import temp_limit_pkg::*;
#(
  parameter int unsigned P_NV_PROG_TIME_NS = 250
) (
  // clock and reset
  input wire logic                   I_CLK,
  input wire logic                   I_RST,
  // bus
  input wire logic                   I_SCL,
  input wire logic                   I_SDA,
  input wire logic                   O_SDA_OUT,
  input wire logic                   O_SDA_OE,
  input wire logic [2:0]             I_ADDRESS_SELECT_PINS,
  // configuration
  input wire logic                   I_RESOLUTION_SELECT_HIGH,
  input wire logic                   I_RESOLUTION_SELECT_LOW,
  input wire logic                   I_REGISTER_LOCK_BIT,
  input wire logic                   I_PERMANENT_LOCKDOWN_BIT,
  // status and limits
  input wire logic                   O_NV_BUSY_FLAG,
  input wire temp_limit_pkg::limit_t O_LOW_LIMIT,
  input wire temp_limit_pkg::limit_t O_HIGH_LIMIT
);
  localparam int unsigned PROG_CYCLES = (P_NV_PROG_TIME_NS + 24) / 25;
  logic [15:0] busy_len;
  limit_t      prev_low;
  limit_t      prev_high;
  logic        prev_rst;
  logic        moved;
  logic        locked;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  ////////////////////////////////////////////////////////////
  always_ff @(posedge I_CLK) begin
    busy_len <= (I_RST || !O_NV_BUSY_FLAG) ? 16'h0000 : busy_len + 16'h0001;
    prev_low <= O_LOW_LIMIT;
    prev_high <= O_HIGH_LIMIT;
    prev_rst <= I_RST;
  end
  // reset reload is not a bus write, so it is left out
  assign moved = !prev_rst && (prev_low != O_LOW_LIMIT || prev_high != O_HIGH_LIMIT);
  assign locked = I_REGISTER_LOCK_BIT || I_PERMANENT_LOCKDOWN_BIT;
  sequence stop_seq;
    I_SCL && $past(I_SCL) && $rose(I_SDA);
  endsequence
  sequence prog_end;
    $fell(O_NV_BUSY_FLAG);
  endsequence
  ////////////////////////////////////////////////////////////
  a_lock_freeze: assert property (locked ##1 locked |-> !moved)
    else $error("limit changed while locked");
  a_busy_freeze: assert property (O_NV_BUSY_FLAG ##1 O_NV_BUSY_FLAG |-> !moved)
    else $error("limit changed while busy");
  a_move_scl_low: assert property (moved |-> !I_SCL && $past(!I_SCL))
    else $error("limit changed outside byte end");
  a_write_masked: assert property (!prev_rst && prev_low != O_LOW_LIMIT |->
    (O_LOW_LIMIT & (`RES_BASE_MASK >> {I_RESOLUTION_SELECT_HIGH, I_RESOLUTION_SELECT_LOW}))
    == 16'h0000) else $error("low limit keeps masked bits");
  a_prog_length: assert property (prog_end |->
    busy_len >= PROG_CYCLES && busy_len <= PROG_CYCLES + 1)
    else $error("program cycle length wrong");
  a_prog_stop: assert property ($rose(O_NV_BUSY_FLAG) |-> I_SCL && I_SDA && $past(I_SCL))
    else $error("program started without stop");
  a_oe_scl_low: assert property ($changed(O_SDA_OE) |-> !I_SCL)
    else $error("data drive changed while clock high");
  a_stop_release: assert property (stop_seq |=> !O_SDA_OE [*2])
    else $error("data line held after stop");
  a_drive_low: assert property (O_SDA_OE |-> O_SDA_OUT == 1'b0)
    else $error("open drain drives high");
  a_reset_quiet: assert property ($fell(I_RST) |-> !O_SDA_OE && !O_NV_BUSY_FLAG)
    else $error("outputs active after reset");
endmodule : temp_limit_sva

bind temp_limit_access temp_limit_sva #(.P_NV_PROG_TIME_NS(P_NV_PROG_TIME_NS)) i_sva (
  .I_CLK(I_CLK), .I_RST(I_RST), .I_SCL(I_SCL), .I_SDA(I_SDA), .O_SDA_OUT(O_SDA_OUT),
  .O_SDA_OE(O_SDA_OE), .I_ADDRESS_SELECT_PINS(I_ADDRESS_SELECT_PINS),
  .I_RESOLUTION_SELECT_HIGH(I_RESOLUTION_SELECT_HIGH),
  .I_RESOLUTION_SELECT_LOW(I_RESOLUTION_SELECT_LOW), .I_REGISTER_LOCK_BIT(I_REGISTER_LOCK_BIT),
  .I_PERMANENT_LOCKDOWN_BIT(I_PERMANENT_LOCKDOWN_BIT), .O_NV_BUSY_FLAG(O_NV_BUSY_FLAG),
  .O_LOW_LIMIT(O_LOW_LIMIT), .O_HIGH_LIMIT(O_HIGH_LIMIT));

// ==== tl_bus_master.sv ====
// two-wire bus master model facing the limit access block
module tl_bus_master (
  // clock
  input  wire logic        i_clk,
  // device drive of the data line
  input  wire logic        i_oe,
  input  wire logic        i_out,
  // bus wires
  output      logic        o_scl,
  output      logic        o_sda,
  // one pulse per finished byte
  output      logic        o_done,
  output      logic [15:0] o_val
);
  timeunit 1ns;
  timeprecision 1ps;
  logic m_sda = 1'b1;
  // pull-up: low while either party pulls it
  assign o_sda = m_sda & (i_oe ? i_out : 1'b1);
  initial begin
    o_scl = 1'b1;
    o_done = 1'b0;
    o_val = 16'h0000;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick
  // also serves as repeated start
  task automatic start_cond();
    m_sda <= 1'b1;
    tick(2);
    o_scl <= 1'b1;
    tick(2);
    m_sda <= 1'b0;
    tick(2);
    o_scl <= 1'b0;
    tick(2);
  endtask : start_cond
  task automatic stop_cond();
    m_sda <= 1'b0;
    tick(2);
    o_scl <= 1'b1;
    tick(2);
    m_sda <= 1'b1;
    tick(2);
  endtask : stop_cond
  // data changes only while the clock is low
  task automatic send_bit(input logic b, output logic r);
    m_sda <= b;
    tick(2);
    o_scl <= 1'b1;
    tick(2);
    r = o_sda;
    tick(1);
    o_scl <= 1'b0;
    tick(2);
  endtask : send_bit
  task automatic publish(input logic [15:0] v);
    o_val <= v;
    o_done <= 1'b1;
    tick(1);
    o_done <= 1'b0;
  endtask : publish
  task automatic wbyte(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) send_bit(b[i], r);
    send_bit(1'b1, r);
    publish({15'h0000, ~r});
  endtask : wbyte
  task automatic rbyte(input logic ack);
    logic [7:0] d;
    logic       r;
    for (int i = 0; i < 8; i++) begin
      send_bit(1'b1, r);
      d = {d[6:0], r};
    end
    send_bit(~ack, r);
    publish({8'h00, d});
  endtask : rbyte
endmodule : tl_bus_master

// ==== tb.sv ====
// self-checking bench of the temperature limit access block
`include "temp_limit_defines.svh"
module tb
  import temp_limit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        rst;
  logic        scl;
  logic        sda;
  logic        sda_out;
  logic        sda_oe;
  logic [2:0]  aaa;
  logic [1:0]  res;
  logic        lock;
  logic        lockdown;
  logic        busy;
  limit_t      low_lim;
  limit_t      high_lim;
  logic        done;
  logic [15:0] got;
  limit_t      exp_q[$];
  int          bad_count;
  int          total_checks;
  int          cycles;
  logic [31:0] seed;
  limit_t      low_keep;
  ////////////////////////////////////////////////////////////
  // long program time so a write can land inside it
  temp_limit_access #(.P_NV_PROG_TIME_NS(25000)) i_dut (
    .I_CLK(clk), .I_RST(rst), .I_SCL(scl), .I_SDA(sda), .O_SDA_OUT(sda_out),
    .O_SDA_OE(sda_oe), .I_ADDRESS_SELECT_PINS(aaa), .I_RESOLUTION_SELECT_HIGH(res[1]),
    .I_RESOLUTION_SELECT_LOW(res[0]), .I_REGISTER_LOCK_BIT(lock),
    .I_PERMANENT_LOCKDOWN_BIT(lockdown), .O_NV_BUSY_FLAG(busy),
    .O_LOW_LIMIT(low_lim), .O_HIGH_LIMIT(high_lim));
  tl_bus_master i_master (.i_clk(clk), .i_oe(sda_oe), .i_out(sda_out), .o_scl(scl),
    .o_sda(sda), .o_done(done), .o_val(got));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic limit_t keep(input limit_t v, input logic [1:0] r);
    return v & ~(16'h007f >> r);
  endfunction : keep
  task automatic check(input string name, input limit_t exp, input limit_t seen);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    if (exp_q.size() != 0) bad_count++;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  task automatic wr(input byte_t ptr, input limit_t d, input int n, input logic ack);
    i_master.start_cond();
    exp_q.push_back(16'h0001);
    i_master.wbyte({`DEV_ADDR_PREFIX, aaa, 1'b0});
    exp_q.push_back(16'h0001);
    i_master.wbyte(ptr);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back({15'h0000, ack});
      i_master.wbyte(i == 0 ? d[15:8] : (i == 1 ? d[7:0] : 8'hff));
    end
    i_master.stop_cond();
  endtask : wr
  task automatic rd(input limit_t v, input int reps);
    i_master.start_cond();
    exp_q.push_back(16'h0001);
    i_master.wbyte({`DEV_ADDR_PREFIX, aaa, 1'b1});
    for (int k = 0; k < reps; k++) begin
      exp_q.push_back({8'h00, v[15:8]});
      i_master.rbyte(1'b1);
      exp_q.push_back({8'h00, v[7:0]});
      i_master.rbyte(k < reps - 1);
    end
    i_master.stop_cond();
  endtask : rd
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      give_verdict();
    end
  end
  always @(posedge clk) begin
    if (done === 1'b1) check("bus result", exp_q.pop_front(), got);
  end
  initial begin
    rst = 1'b1;
    res = 2'b11;
    lock = 1'b0;
    lockdown = 1'b0;
    seed = lfsr(32'h18e2);
    aaa = seed[2:0];
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("low limit", 16'h4b00, low_lim);
    check("high limit", 16'h5000, high_lim);
    wr(`PTR_HIGH_LIMIT, 16'h5a37, 2, 1'b1);
    check("high limit", 16'h5a30, high_lim);
    rd(16'h5a30, 2);
    for (int r = 0; r < 4; r++) begin
      seed = lfsr(seed);
      res <= 2'(r);
      aaa <= seed[5:3];
      @(posedge clk);
      // negative values keep the high limit above the low one
      low_keep = keep({1'b1, seed[14:0]}, 2'(r));
      wr(`PTR_LOW_LIMIT, {1'b1, seed[14:0]}, 2, 1'b1);
      check("low limit", low_keep, low_lim);
      res <= 2'(3 - r);
      @(posedge clk);
      rd(keep(low_keep, 2'(3 - r)), 1);
    end
    for (int r = 0; r < 2; r++) begin
      {lockdown, lock} <= 2'b01 << r;
      @(posedge clk);
      wr(`PTR_HIGH_LIMIT, 16'h7000, 2, 1'b1);
      check("high limit", 16'h5a30, high_lim);
    end
    {lockdown, lock} <= 2'b00;
    i_master.start_cond();
    exp_q.push_back(16'h0000);
    i_master.wbyte({`DEV_ADDR_PREFIX, ~aaa, 1'b0});
    i_master.stop_cond();
    wr(`PTR_NV_LOW_LIMIT, 16'h1230, 3, 1'b1);
    repeat (4) @(posedge clk);
    check("busy", 16'h0001, {15'h0000, busy});
    wr(`PTR_LOW_LIMIT, 16'h0100, 2, 1'b0);
    check("low limit", low_keep, low_lim);
    for (int k = 0; k < 2000 && busy !== 1'b0; k++) @(posedge clk);
    check("busy", 16'h0000, {15'h0000, busy});
    wr(`PTR_NV_LOW_LIMIT, 16'h0000, 0, 1'b1);
    rd(16'h1200, 1);
    wr(`PTR_NV_HIGH_LIMIT, 16'h7700, 1, 1'b1);
    repeat (4) @(posedge clk);
    check("busy", 16'h0000, {15'h0000, busy});
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("low limit", 16'h1200, low_lim);
    check("high limit", 16'h5000, high_lim);
    give_verdict();
  end
endmodule : tb
